/* File: src/ssx_pkg.sv */
// Package of the skip, swap, table-read and exclusive-OR execution block.
// Assumes one 40 MHz clock and a single AHB-Lite master for the register port.
package ssx_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int ROM_W = 14;
  localparam int HI_W = ROM_W - DATA_W;
  localparam int PAGE_W = 3;
  localparam int ROM_AW = PAGE_W + DATA_W;
  localparam int BIT_W = 3;
  localparam int FLAGS_W = 6;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;

  // Flag positions inside the flag register
  localparam int FLG_C = 0;
  localparam int FLG_HC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_SOV = 3;
  localparam int FLG_PWD = 4;
  localparam int FLG_WDT = 5;

  // Status register bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;

  // Register byte offsets
  localparam int OFS_W = 8;
  localparam logic [OFS_W-1:0] OFS_ACC = 8'h00;
  localparam logic [OFS_W-1:0] OFS_FLAGS = 8'h04;
  localparam logic [OFS_W-1:0] OFS_TP = 8'h08;
  localparam logic [OFS_W-1:0] OFS_THL = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_STAT = 8'h10;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [DATA_W-1:0] TP_RST = 8'h00;
  localparam logic [HI_W-1:0] THL_RST = 6'h00;

  // AHB constants
  localparam int HTRANS_ACT = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_NIBX = 4'b0001,
    OP_ZBYTE = 4'b0010,
    OP_CPZ = 4'b0011,
    OP_SZBIT = 4'b0100,
    OP_TRDC = 4'b0101,
    OP_TRDL = 4'b0110,
    OP_XORA = 4'b0111,
    OP_XMEM = 4'b1000,
    OP_XORI = 4'b1001
  } ssx_op_e;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_DUMMY = 2'b01,
    ST_TABLE = 2'b10
  } ssx_state_e;

  // True when a byte is all zeros
  function automatic logic is_null(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction
endpackage

/* File: src/ssx_alu_if.sv */
// Interface between the execution core and its combinational operator.
// Assumes both ends sit in the same clock domain; it carries no timing.
`timescale 1ns/1ps
`default_nettype none
interface ssx_alu_if;
  import ssx_pkg::*;
  ssx_op_e op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] mem;
  logic [DATA_W-1:0] literal;
  logic [BIT_W-1:0] bit_sel;
  logic [DATA_W-1:0] result;
  logic zero;
  logic skip;
  logic acc_we;
  logic mem_we;
  logic z_we;
  modport core (output op, acc, mem, literal, bit_sel, input result, zero, skip, acc_we, mem_we, z_we);
  modport alu (input op, acc, mem, literal, bit_sel, output result, zero, skip, acc_we, mem_we, z_we);
endinterface
`default_nettype wire

/* File: src/ssx_alu.sv */
// Combinational operator: swap, skip tests and the three exclusive-OR forms.
// Assumes operands are stable for the whole execute cycle.
`timescale 1ns/1ps
`default_nettype none
module ssx_alu
  import ssx_pkg::*;
(
  // Operand and result bundle
  ssx_alu_if.alu a
);
  // Decode and compute; table reads need no operator work
  always_comb begin
    a.result = a.mem;
    a.skip = 1'b0;
    a.acc_we = 1'b0;
    a.mem_we = 1'b0;
    a.z_we = 1'b0;
    case (a.op)
      OP_NIBX: begin
        a.result = {a.mem[NIB_W-1:0], a.mem[DATA_W-1:NIB_W]};
        a.acc_we = 1'b1;
      end
      OP_ZBYTE: begin
        a.skip = is_null(a.mem);
      end
      OP_CPZ: begin
        a.acc_we = 1'b1;
        a.skip = is_null(a.mem);
      end
      OP_SZBIT: begin
        a.skip = ~a.mem[a.bit_sel];
      end
      OP_XORA: begin
        a.result = a.acc ^ a.mem;
        a.acc_we = 1'b1;
        a.z_we = 1'b1;
      end
      OP_XMEM: begin
        a.result = a.acc ^ a.mem;
        a.mem_we = 1'b1;
        a.z_we = 1'b1;
      end
      OP_XORI: begin
        a.result = a.acc ^ a.literal;
        a.acc_we = 1'b1;
        a.z_we = 1'b1;
      end
      default: begin
        a.result = a.mem;
      end
    endcase
  end

  // Zero test on the 8-bit result
  assign a.zero = is_null(a.result);
endmodule
`default_nettype wire

/* File: src/ssx_exec.sv */
// Execution core for swap, skip, table read and exclusive-OR instructions.
// Assumes the fetch pipeline presents the addressed data byte with the opcode,
// and program memory answers combinationally to the registered address.
// Operation
// - Swap memory nibbles into accumulator, flags kept
// - Zero byte: discard prefetch, dummy cycle
// - Copy byte to accumulator; skip when zero
// - Selected bit clear: discard prefetch, dummy cycle
// - Current-page table read: low byte, high latch
// - Last-page table read: low byte, high latch
// - Accumulator xor memory into accumulator, Z only
// - Accumulator xor memory into memory, Z only
// - Accumulator xor literal into accumulator, Z only
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssx_exec
  import ssx_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Instruction issue from the fetch pipeline
  input wire logic instr_valid,
  input wire ssx_op_e instr_op,
  input wire logic [BIT_W-1:0] instr_bit,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [PAGE_W-1:0] pc_page,
  output logic instr_ready,
  output logic discard_next,
  // Data memory write port
  output logic mem_we,
  output logic [DATA_W-1:0] mem_wdata,
  // Program memory read port
  output logic rom_re,
  output logic [ROM_AW-1:0] rom_addr,
  input wire logic [ROM_W-1:0] rom_rdata,
  // Architectural state
  output logic [DATA_W-1:0] accumulator,
  output logic [FLAGS_W-1:0] flags,
  output logic [HI_W-1:0] table_high_latch
);
  ssx_state_e state_reg, state_next;
  logic [DATA_W-1:0] acc_reg, table_pointer_reg;
  logic [FLAGS_W-1:0] flags_reg;
  logic [HI_W-1:0] thl_reg;
  logic ready_reg, discard_reg, mem_we_reg, rom_re_reg, skip_seen_reg;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic [ROM_AW-1:0] rom_addr_reg;
  logic wr_pend_reg, rd_pend_reg, hready_reg;
  logic [OFS_W-1:0] bus_ofs_reg;
  logic [31:0] hrdata_reg;
  logic taken, tbl_op, bus_start, bus_wr_acc, bus_wr_flags, bus_wr_tp;
  ssx_alu_if alu_bus ();

  ssx_alu u_alu (
    .a(alu_bus)
  );

  // Operands go straight to the operator
  assign alu_bus.op = instr_op;
  assign alu_bus.acc = acc_reg;
  assign alu_bus.mem = mem_rdata;
  assign alu_bus.literal = instr_literal;
  assign alu_bus.bit_sel = instr_bit;

  assign taken = instr_valid && ready_reg;
  assign tbl_op = (instr_op == OP_TRDC) || (instr_op == OP_TRDL);

  // Next state: skips add one dummy cycle, table reads one fetch cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC: begin
        if (taken && tbl_op) begin
          state_next = ST_TABLE;
        end else if (taken && alu_bus.skip) begin
          state_next = ST_DUMMY;
        end
      end
      ST_DUMMY: state_next = ST_EXEC;
      ST_TABLE: state_next = ST_EXEC;
      default: state_next = ST_EXEC;
    endcase
  end

  // Sequencer and issue handshake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_EXEC;
      ready_reg <= 1'b0;
      discard_reg <= 1'b0;
      skip_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_EXEC);
      discard_reg <= taken && !tbl_op && alu_bus.skip;
      if (taken && !tbl_op) begin
        skip_seen_reg <= alu_bus.skip;
      end
    end
  end

  // Program memory address; the page is latched with the table pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_addr_reg <= '0;
      rom_re_reg <= 1'b0;
    end else begin
      rom_re_reg <= taken && tbl_op;
      if (taken && instr_op == OP_TRDC) begin
        rom_addr_reg <= {pc_page, table_pointer_reg};
      end else if (taken && instr_op == OP_TRDL) begin
        rom_addr_reg <= {LAST_PAGE, table_pointer_reg};
      end
    end
  end

  // Data memory write: operator result or table low byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= '0;
    end else begin
      mem_we_reg <= (taken && alu_bus.mem_we) || (state_reg == ST_TABLE);
      if (state_reg == ST_TABLE) begin
        mem_wdata_reg <= rom_rdata[DATA_W-1:0];
      end else if (taken && alu_bus.mem_we) begin
        mem_wdata_reg <= alu_bus.result;
      end
    end
  end

  // Table high latch takes the upper bits of the fetched word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thl_reg <= THL_RST;
    end else if (state_reg == ST_TABLE) begin
      thl_reg <= rom_rdata[ROM_W-1:DATA_W];
    end
  end

  // Accumulator; the instruction beats a bus write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= ACC_RST;
    end else if (taken && alu_bus.acc_we) begin
      acc_reg <= alu_bus.result;
    end else if (bus_wr_acc) begin
      acc_reg <= hwdata[DATA_W-1:0];
    end
  end

  // Flags: only Z moves under these instructions, the rest stay put
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= FLAGS_RST;
    end else if (taken && alu_bus.z_we) begin
      flags_reg[FLG_Z] <= alu_bus.zero;
    end else if (bus_wr_flags) begin
      flags_reg <= hwdata[FLAGS_W-1:0];
    end
  end

  // Table pointer is loaded by software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_pointer_reg <= TP_RST;
    end else if (bus_wr_tp) begin
      table_pointer_reg <= hwdata[DATA_W-1:0];
    end
  end

  // Bus address phase; reads take one wait state so hrdata can be registered
  assign bus_start = hsel && htrans[HTRANS_ACT] && hready;
  assign bus_wr_acc = wr_pend_reg && bus_ofs_reg == OFS_ACC;
  assign bus_wr_flags = wr_pend_reg && bus_ofs_reg == OFS_FLAGS;
  assign bus_wr_tp = wr_pend_reg && bus_ofs_reg == OFS_TP;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      bus_ofs_reg <= '0;
      hready_reg <= 1'b1;
      hrdata_reg <= '0;
    end else begin
      wr_pend_reg <= bus_start && hwrite;
      rd_pend_reg <= bus_start && !hwrite;
      hready_reg <= !(bus_start && !hwrite);
      if (bus_start) begin
        bus_ofs_reg <= haddr[OFS_W-1:0];
      end
      if (rd_pend_reg) begin
        case (bus_ofs_reg)
          OFS_ACC: hrdata_reg <= {24'h000000, acc_reg};
          OFS_FLAGS: hrdata_reg <= {26'h0000000, flags_reg};
          OFS_TP: hrdata_reg <= {24'h000000, table_pointer_reg};
          OFS_THL: hrdata_reg <= {26'h0000000, thl_reg};
          OFS_STAT: hrdata_reg <= {30'h00000000, skip_seen_reg, state_reg != ST_EXEC};
          default: hrdata_reg <= 32'h00000000; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Outputs straight from flops; hresp tied low
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign instr_ready = ready_reg;
  assign discard_next = discard_reg;
  assign mem_we = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;
  assign rom_re = rom_re_reg;
  assign rom_addr = rom_addr_reg;
  assign accumulator = acc_reg;
  assign flags = flags_reg;
  assign table_high_latch = thl_reg;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence skip_s;
    discard_reg && !ready_reg ##1 !discard_reg && ready_reg;
  endsequence
  sequence noskip_s;
    !discard_reg && ready_reg;
  endsequence
  sequence table_s(logic [PAGE_W-1:0] pg);
    rom_re_reg && rom_addr_reg == {pg, $past(table_pointer_reg)} ##1 mem_we_reg
      && mem_wdata_reg == $past(rom_rdata[DATA_W-1:0]) && thl_reg == $past(rom_rdata[ROM_W-1:DATA_W]);
  endsequence

  swap_acc_a: assert property (taken && instr_op == OP_NIBX |=> acc_reg == {$past(mem_rdata[NIB_W-1:0]),
    $past(mem_rdata[DATA_W-1:NIB_W])} && $stable(flags_reg)) else $error("nibble swap wrong");
  zbyte_skip_a: assert property (taken && instr_op == OP_ZBYTE && mem_rdata == '0 |=> skip_s)
    else $error("zero byte skip wrong");
  zbyte_noskip_a: assert property (taken && instr_op == OP_ZBYTE && mem_rdata != '0 |=> noskip_s)
    else $error("nonzero byte skipped");
  copy_skip_a: assert property (taken && instr_op == OP_CPZ |=> acc_reg == $past(mem_rdata)
    && discard_reg == (acc_reg == '0) && $stable(flags_reg)) else $error("copy and skip wrong");
  bit_skip_a: assert property (taken && instr_op == OP_SZBIT |=> discard_reg == !$past(mem_rdata[instr_bit]))
    else $error("bit skip wrong");
  tbl_cur_a: assert property (taken && instr_op == OP_TRDC |=> table_s($past(pc_page)))
    else $error("current page read wrong");
  tbl_last_a: assert property (taken && instr_op == OP_TRDL |=> table_s(LAST_PAGE) ##0 $stable(flags_reg))
    else $error("last page read wrong");
  xor_acc_a: assert property (taken && instr_op == OP_XORA |=> acc_reg == ($past(acc_reg) ^ $past(mem_rdata))
    && flags_reg[FLG_C] == $past(flags_reg[FLG_C]) && flags_reg[FLG_WDT] == $past(flags_reg[FLG_WDT]))
    else $error("xor into acc wrong");
  xor_mem_a: assert property (taken && instr_op == OP_XMEM |=> mem_we_reg && $stable(acc_reg)
    && mem_wdata_reg == ($past(acc_reg) ^ $past(mem_rdata))) else $error("xor into memory wrong");
  xor_lit_a: assert property (taken && instr_op == OP_XORI |=> acc_reg == ($past(acc_reg) ^ $past(instr_literal)))
    else $error("xor literal wrong");
  zero_flag_a: assert property (taken && alu_bus.z_we |=> flags_reg[FLG_Z] == ($past(alu_bus.result) == '0))
    else $error("zero flag wrong");
endmodule
`default_nettype wire

/* File: tb/ssx_far_model.sv */
// Far-side model: program memory and the data memory write port.
// Assumes the block drives a registered read address and a one-cycle write pulse.
`timescale 1ns/1ps
`default_nettype none
module ssx_far_model
  import ssx_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Program memory read port
  input wire logic rom_re,
  input wire logic [ROM_AW-1:0] rom_addr,
  output logic [ROM_W-1:0] rom_rdata,
  // Data memory write port and what it captured
  input wire logic mem_we,
  input wire logic [DATA_W-1:0] mem_wdata,
  output logic [DATA_W-1:0] mem_byte,
  output logic [7:0] mem_writes
);
  // Each word is derived from its address, so a wrong page or pointer shows
  function automatic logic [ROM_W-1:0] word_at(input logic [ROM_AW-1:0] a);
    return {a[10:5], a[7:0] ^ 8'ha5};
  endfunction

  // Answers at once while read; otherwise the inverse, so a late sample is caught
  assign rom_rdata = rom_re ? word_at(rom_addr) : ~word_at(rom_addr);

  // Capture every byte written back and count the pulses
  initial begin
    mem_byte = 8'h00;
    mem_writes = 8'h00;
  end
  always @(posedge hclk) begin
    if (mem_we === 1'b1) begin
      mem_byte <= mem_wdata;
      mem_writes <= mem_writes + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: tb/skip_swap_table_xor_exec_tb.sv */
// Testbench for the skip, swap, table-read and exclusive-OR execution block.
// Assumes ssx_far_model as program memory; the bench is bus master and fetch stage.
`timescale 1ns/1ps
`default_nettype none
module skip_swap_table_xor_exec_tb import ssx_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic instr_valid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  ssx_op_e instr_op = OP_NOP;
  logic [BIT_W-1:0] instr_bit = 3'h0;
  logic [DATA_W-1:0] instr_literal = 8'h00;
  logic [DATA_W-1:0] mem_rdata = 8'h00;
  logic [PAGE_W-1:0] pc_page = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, instr_ready, discard_next, mem_we, rom_re;
  logic [DATA_W-1:0] mem_wdata, accumulator, mem_byte, r, a;
  logic [7:0] mem_writes;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_W-1:0] rom_rdata;
  logic [FLAGS_W-1:0] flags;
  logic [HI_W-1:0] table_high_latch;
  logic [PAGE_W-1:0] ep;
  logic [31:0] rd;
  logic sk;
  logic [FLAGS_W-1:0] xf;
  int fail_count = 0;
  int samples_checked = 0;
  ssx_op_e sop[6] = '{OP_ZBYTE, OP_ZBYTE, OP_CPZ, OP_CPZ, OP_SZBIT, OP_SZBIT};
  logic [7:0] sm[6] = '{8'h01, 8'h00, 8'h80, 8'h00, 8'h01, 8'h7f};
  logic [2:0] sb[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7};
  ssx_op_e xo[6] = '{OP_XORA, OP_XORA, OP_XORI, OP_XORI, OP_XMEM, OP_XMEM};
  logic [7:0] xv[6] = '{8'h3c, 8'h5a, 8'h5a, 8'h0f, 8'h0f, 8'hf0};

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  ssx_exec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_bit(instr_bit), .instr_literal(instr_literal), .mem_rdata(mem_rdata), .pc_page(pc_page),
    .instr_ready(instr_ready), .discard_next(discard_next), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .rom_re(rom_re), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .accumulator(accumulator),
    .flags(flags), .table_high_latch(table_high_latch));

  ssx_far_model far (.hclk(hclk), .rom_re(rom_re), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_byte(mem_byte), .mem_writes(mem_writes));

  // Report and end the run
  task test_done;
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask

  task rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(nm, e, rd);
  endtask

  // Offer one instruction; returns 1 ns after the edge that took it
  task issue(input ssx_op_e op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] lit);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge hclk);
      #1;
      n++;
    end
    // A core that never becomes ready is a failure, not a hang
    if (instr_ready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_bit <= b;
    instr_literal <= lit;
    mem_rdata <= m;
    @(posedge hclk);
    instr_valid <= 1'b0;
    mem_rdata <= ~m;
    instr_literal <= ~lit;
    #1;
  endtask

  // Issue and compare skip pulse, stall, write pulse and state, then the cycle after
  task exec(input ssx_op_e op, input logic [7:0] m, input logic [7:0] lit, input logic [2:0] b,
            input logic s, input logic we, input logic [7:0] wd, input logic [7:0] ea,
            input logic [5:0] ef);
    issue(op, m, b, lit);
    chk("discard", {31'h0, s}, discard_next);
    chk("ready", {31'h0, !s}, instr_ready);
    chk("mem_we", {31'h0, we}, mem_we);
    if (we) begin
      chk("mem_wdata", {24'h0, wd}, mem_wdata);
    end
    chk("acc", {24'h0, ea}, accumulator);
    chk("flags", {26'h0, ef}, flags);
    @(posedge hclk);
    #1;
    chk("ready next", 32'h1, instr_ready);
    chk("discard next", 32'h0, discard_next);
    chk("mem_we next", 32'h0, mem_we);
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("acc reset", OFS_ACC, 32'h0);
    rdchk("flags reset", OFS_FLAGS, 32'h0);
    rdchk("pointer reset", OFS_TP, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'h3b);
    bus(1'b1, OFS_ACC, 32'h5a);
    bus(1'b1, OFS_THL, 32'h3f);
    rdchk("flags rw", OFS_FLAGS, 32'h3b);
    rdchk("acc rw", OFS_ACC, 32'h5a);
    rdchk("latch ro", OFS_THL, 32'h0);
    exec(OP_NIBX, 8'h3c, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00, 8'hc3, 6'h3b);
    a = 8'hc3;
    // Skip family: byte zero, copy then zero test, single bit clear
    for (int i = 0; i < 6; i++) begin
      sk = (sop[i] == OP_SZBIT) ? !sm[i][sb[i]] : (sm[i] == 8'h00);
      if (sop[i] == OP_CPZ) begin
        a = sm[i];
      end
      exec(sop[i], sm[i], 8'h00, sb[i], sk, 1'b0, 8'h00, a, 6'h3b);
    end
    rdchk("last skip", OFS_STAT, 32'h2);
    // Table reads: current page follows pc_page, last page ignores it
    bus(1'b1, OFS_TP, 32'h9e);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      pc_page <= i ? 3'h5 : 3'h2;
      #1;
      ep = i ? LAST_PAGE : 3'h2;
      issue(i ? OP_TRDL : OP_TRDC, 8'h00, 3'h0, 8'h00);
      chk("rom_re", 32'h1, rom_re);
      chk("rom_addr", {21'h0, ep, 8'h9e}, rom_addr);
      chk("ready", 32'h0, instr_ready);
      @(posedge hclk);
      #1;
      chk("table we", 32'h1, mem_we);
      chk("table low", {24'h0, 8'h9e ^ 8'ha5}, mem_wdata);
      chk("table high", {26'h0, ep, 3'h4}, table_high_latch);
      chk("flags", 32'h3b, flags);
      chk("acc", {24'h0, a}, accumulator);
    end
    rdchk("latch read", OFS_THL, 32'h3c);
    // Exclusive-OR forms, each with a zero and a non-zero result
    bus(1'b1, OFS_ACC, 32'h3c);
    a = 8'h3c;
    for (int i = 0; i < 6; i++) begin
      r = a ^ xv[i];
      // Only the zero flag may move away from the value written earlier
      xf = (r == 8'h00) ? 6'h3f : 6'h3b;
      exec(xo[i], (xo[i] == OP_XORI) ? ~xv[i] : xv[i], (xo[i] == OP_XORI) ? xv[i] : ~xv[i], 3'h0, 1'b0,
        xo[i] == OP_XMEM, r, (xo[i] == OP_XMEM) ? a : r, xf);
      if (xo[i] != OP_XMEM) begin
        a = r;
      end
    end
    chk("stored byte", 32'hff, mem_byte);
    chk("write count", 32'h4, mem_writes);
    test_done();
  end
endmodule
`default_nettype wire
